/* File: rtl/xlate_op_regs.sv */
// Stage-1 translation command and status registers of one context bank.
// Assumes an AXI4-Lite master with one write and one read in flight at most.

// What this block does
// - Command write starts translation, result stored
// - Commands are 64-bit write-only, read zero
// - Low-word write zero-extends to 64 bits
// - Upper-word-only write ignored, no translation
// - Address in bits 31:12 in both modes, 11:0 reserved
// - Narrow mode: 32-bit command, address 31:12
// - Status 32-bit read-only, resets zero
// - Status bit 0 shows operation in progress
// - Stage-1 commands optional, may be disabled
module xlate_op_regs
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write address channel
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // Write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // Write response channel
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read address channel
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // Read data channel
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Status toward the context bank
    output logic             xlate_active,
    output logic             result_valid
);
    xlate_req_if req ();

    xlate_engine u_engine
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .req     (req)
    );

    // Write channel holding registers
    logic        aw_held_reg;
    logic [11:0] aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;

    // Read channel registers
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // Control and state
    logic [1:0]  config_reg;
    logic        active_reg;
    logic        result_valid_reg;
    logic [63:0] result_reg;
    logic [1:0]  last_cmd_reg;
    logic        start_reg;
    logic [1:0]  start_cmd_reg;
    logic [63:0] start_addr_reg;

    // Write decode
    wire logic        wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;
    wire logic [11:0] wr_word   = {aw_addr_reg[11:2], 2'b00};
    wire logic        wide_mode = config_reg[xlate_pkg::CFG_WIDE_BIT];
    wire logic        s1_enable = config_reg[xlate_pkg::CFG_ENABLE_BIT];

    wire logic wr_cmd_lo = (wr_word == xlate_pkg::OFF_PRIV_READ_LO)
                        || (wr_word == xlate_pkg::OFF_PRIV_WRITE_LO)
                        || (wr_word == xlate_pkg::OFF_USER_READ_LO)
                        || (wr_word == xlate_pkg::OFF_USER_WRITE_LO);
    wire logic wr_cmd_hi = (wr_word == xlate_pkg::OFF_PRIV_READ_HI)
                        || (wr_word == xlate_pkg::OFF_PRIV_WRITE_HI)
                        || (wr_word == xlate_pkg::OFF_USER_READ_HI)
                        || (wr_word == xlate_pkg::OFF_USER_WRITE_HI);
    wire logic wr_config = (wr_word == xlate_pkg::OFF_CONFIG);
    wire logic wr_ro     = (wr_word == xlate_pkg::OFF_STATUS)
                        || (wr_word == xlate_pkg::OFF_RESULT_LO)
                        || (wr_word == xlate_pkg::OFF_RESULT_HI)
                        || (wr_word == xlate_pkg::OFF_LAST_CMD);
    wire logic wr_mapped = wr_cmd_lo || wr_cmd_hi || wr_config || wr_ro;

    // Only a full low-word write starts; a busy engine drops the command
    wire logic wr_full   = (w_strb_reg == 4'hf);
    wire logic cmd_start = wr_fire && wr_cmd_lo && wr_full && s1_enable
                        && !active_reg;
    wire xlate_pkg::xlate_cmd_e cmd_sel = xlate_pkg::xlate_cmd_e'(wr_word[4:3]);

    // Address field: 31:12 in both wide and narrow mode, upper word zero-filled
    wire logic [63:0] cmd_addr = wide_mode
        ? {32'h0000_0000, w_data_reg[31:xlate_pkg::ADDR_LSB], 12'h000}
        : {32'h0000_0000, w_data_reg[31:xlate_pkg::ADDR_LSB], 12'h000};

    // Config write by byte lane 0
    wire logic [1:0] config_next = (wr_fire && wr_config && w_strb_reg[0])
                                 ? w_data_reg[1:0] : config_reg;

    // Read decode
    wire logic        rd_take = s_axi_arvalid && !rvalid_reg;
    wire logic [11:0] rd_word = {s_axi_araddr[11:2], 2'b00};
    wire logic rd_cmd = (rd_word == xlate_pkg::OFF_PRIV_READ_LO)
                     || (rd_word == xlate_pkg::OFF_PRIV_READ_HI)
                     || (rd_word == xlate_pkg::OFF_PRIV_WRITE_LO)
                     || (rd_word == xlate_pkg::OFF_PRIV_WRITE_HI)
                     || (rd_word == xlate_pkg::OFF_USER_READ_LO)
                     || (rd_word == xlate_pkg::OFF_USER_READ_HI)
                     || (rd_word == xlate_pkg::OFF_USER_WRITE_LO)
                     || (rd_word == xlate_pkg::OFF_USER_WRITE_HI);
    wire logic [31:0] status_word = {31'h0000_0000, active_reg};
    wire logic rd_other = (rd_word == xlate_pkg::OFF_STATUS)
                       || (rd_word == xlate_pkg::OFF_CONFIG)
                       || (rd_word == xlate_pkg::OFF_RESULT_LO)
                       || (rd_word == xlate_pkg::OFF_RESULT_HI)
                       || (rd_word == xlate_pkg::OFF_LAST_CMD);
    logic [31:0] rd_value;

    always_comb
    begin
        case (rd_word)
            xlate_pkg::OFF_STATUS:    rd_value = status_word;
            xlate_pkg::OFF_CONFIG:    rd_value = {30'h0000_0000, config_reg};
            xlate_pkg::OFF_RESULT_LO: rd_value = result_reg[31:0];
            xlate_pkg::OFF_RESULT_HI: rd_value = result_reg[63:32];
            xlate_pkg::OFF_LAST_CMD:  rd_value = {30'h0000_0000, last_cmd_reg};
            default:                  rd_value = 32'h0000_0000;
        endcase
    end

    // Write address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_reg)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && !w_held_reg)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_reg <= 1'b0;
        end
    end

    // Write response; status and result writes are ignored with OKAY
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= xlate_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? xlate_pkg::RESP_OKAY : xlate_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    // Read response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= xlate_pkg::RESP_OKAY;
        end
        else if (rd_take)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_value;
            rresp_reg  <= (rd_cmd || rd_other) ? xlate_pkg::RESP_OKAY : xlate_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // Command launch toward the engine
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_reg      <= 1'b0;
            start_cmd_reg  <= 2'h0;
            start_addr_reg <= 64'h0000_0000_0000_0000;
            last_cmd_reg   <= 2'h0;
            config_reg     <= xlate_pkg::CONFIG_RESET;
        end
        else
        begin
            config_reg <= config_next;
            start_reg  <= cmd_start;
            if (cmd_start)
            begin
                start_cmd_reg  <= cmd_sel;
                start_addr_reg <= cmd_addr;
                last_cmd_reg   <= cmd_sel;
            end
        end
    end

    // Busy flag and result capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            active_reg       <= xlate_pkg::STATUS_RESET[xlate_pkg::STATUS_ACT_BIT];
            result_valid_reg <= 1'b0;
            result_reg       <= 64'h0000_0000_0000_0000;
        end
        else if (cmd_start)
        begin
            active_reg       <= 1'b1;
            result_valid_reg <= 1'b0;
        end
        else if (req.done)
        begin
            active_reg       <= 1'b0;
            result_valid_reg <= 1'b1;
            result_reg       <= req.result;
        end
    end

    assign req.start   = start_reg;
    assign req.cmd     = xlate_pkg::xlate_cmd_e'(start_cmd_reg);
    assign req.in_addr = start_addr_reg;

    // Bus outputs
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready  = !w_held_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign xlate_active  = active_reg;
    assign result_valid  = result_valid_reg;
endmodule : xlate_op_regs

/* File: shared/xlate_pkg.sv */
// Constants for the stage-1 translation command register slice.
// Assumes a 32-bit AXI4-Lite register port on one clock.
package xlate_pkg;
    // Register byte offsets, one aligned word each, 64-bit registers take two
    localparam logic [11:0] OFF_PRIV_READ_LO  = 12'h000;
    localparam logic [11:0] OFF_PRIV_READ_HI  = 12'h004;
    localparam logic [11:0] OFF_PRIV_WRITE_LO = 12'h008;
    localparam logic [11:0] OFF_PRIV_WRITE_HI = 12'h00c;
    localparam logic [11:0] OFF_USER_READ_LO  = 12'h010;
    localparam logic [11:0] OFF_USER_READ_HI  = 12'h014;
    localparam logic [11:0] OFF_USER_WRITE_LO = 12'h018;
    localparam logic [11:0] OFF_USER_WRITE_HI = 12'h01c;
    localparam logic [11:0] OFF_STATUS        = 12'h020;
    localparam logic [11:0] OFF_CONFIG        = 12'h024;
    localparam logic [11:0] OFF_RESULT_LO     = 12'h028;
    localparam logic [11:0] OFF_RESULT_HI     = 12'h02c;
    localparam logic [11:0] OFF_LAST_CMD      = 12'h030;

    // Field positions
    localparam int ADDR_LSB       = 12;
    localparam int STATUS_ACT_BIT = 0;
    localparam int CFG_WIDE_BIT   = 0;
    localparam int CFG_ENABLE_BIT = 1;

    // Reset values
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [1:0]  CONFIG_RESET = 2'h3;

    // Translation engine latency, time and derived cycles at 100 MHz
    localparam int CLK_PERIOD_NS   = 10;
    localparam int XLATE_TIME_NS   = 80;
    localparam int XLATE_CYCLES    = (XLATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        CMD_PRIV_READ  = 2'b00,
        CMD_PRIV_WRITE = 2'b01,
        CMD_USER_READ  = 2'b10,
        CMD_USER_WRITE = 2'b11
    } xlate_cmd_e;
endpackage : xlate_pkg

/* File: shared/xlate_req_if.sv */
// Request and result carrier between the register slice and its engine.
// Assumes both ends run on the same clock.
interface xlate_req_if;
    logic                    start;
    xlate_pkg::xlate_cmd_e   cmd;
    logic [63:0]             in_addr;
    logic                    done;
    logic [63:0]             result;

    modport regs
    (
        output start,
        output cmd,
        output in_addr,
        input  done,
        input  result
    );
    modport engine
    (
        input  start,
        input  cmd,
        input  in_addr,
        output done,
        output result
    );
endinterface : xlate_req_if

/* File: rtl/xlate_engine.sv */
// Stand-in translation engine: fixed latency, flat identity mapping.
// Assumes start is a one-cycle pulse, never given while busy.
module xlate_engine
(
    // Clock and reset
    input wire logic    aclk,
    input wire logic    aresetn,
    // Request channel
    xlate_req_if.engine req
);
    logic [7:0]  count_reg;
    logic        busy_reg;
    logic [63:0] addr_reg;
    logic [1:0]  cmd_reg;
    logic        done_reg;

    wire logic last_cycle = busy_reg && (count_reg == 8'(xlate_pkg::XLATE_CYCLES - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_reg <= 8'h00;
            busy_reg  <= 1'b0;
            addr_reg  <= 64'h0000_0000_0000_0000;
            cmd_reg   <= 2'h0;
            done_reg  <= 1'b0;
        end
        else
        begin
            done_reg <= last_cycle;
            if (req.start)
            begin
                busy_reg  <= 1'b1;
                count_reg <= 8'h00;
                addr_reg  <= req.in_addr;
                cmd_reg   <= req.cmd;
            end
            else if (last_cycle)
                busy_reg <= 1'b0;
            else if (busy_reg)
                count_reg <= count_reg + 8'h01;
        end
    end

    // Page address passes through, low bits record the access kind
    assign req.done   = done_reg;
    assign req.result = {addr_reg[63:12], 10'h000, cmd_reg};
endmodule : xlate_engine

/* File: verif/xlate_op_regs_assertions.sv */
// Port-level checks for the translation command register slice.
// Assumes binding to xlate_op_regs on one clock with synchronous reset.
module xlate_op_regs_assertions
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write channels
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    // Read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // Status
    input wire logic        xlate_active,
    input wire logic        result_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic en_reg;
    wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire cmd_wr  = wr_take && (s_axi_awaddr < xlate_pkg::OFF_STATUS);
    wire lo_go   = cmd_wr && !s_axi_awaddr[2] && (s_axi_wstrb == 4'hf) && !xlate_active && en_reg;
    wire cfg_wr  = wr_take && (s_axi_awaddr == xlate_pkg::OFF_CONFIG) && s_axi_wstrb[0];
    // Shadow of the stage-1 enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            en_reg <= 1'b1;
        else if (cfg_wr)
            en_reg <= s_axi_wdata[1];
    end
    AST_RESET_IDLE: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !xlate_active)
        else $error("outputs not idle after reset");
    AST_LO_START: assert property (lo_go |-> ##2 $rose(xlate_active))
        else $error("low word command did not start");
    AST_HI_IGNORED: assert property (cmd_wr && s_axi_awaddr[2] |-> ##2 !$rose(xlate_active))
        else $error("upper word write started a translation");
    AST_START_WITH_B: assert property ($rose(xlate_active) |-> $rose(s_axi_bvalid))
        else $error("busy rose without a write response");
    AST_ACTIVE_BOUND: assert property ($rose(xlate_active) |-> ##[1:20] !xlate_active)
        else $error("translation never completed");
    AST_DONE_RESULT: assert property ($fell(xlate_active) |-> result_valid)
        else $error("busy fell without a result");
    AST_B_ANSWER: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_CMD_READ_ZERO: assert property (rd_take && s_axi_araddr < xlate_pkg::OFF_STATUS |=>
        s_axi_rvalid && s_axi_rdata == 32'h0000_0000 && s_axi_rresp == xlate_pkg::RESP_OKAY)
        else $error("command register read not zero");
    AST_STATUS_READ: assert property (rd_take && s_axi_araddr == xlate_pkg::OFF_STATUS |=>
        s_axi_rdata[31:1] == 31'h0000_0000 &&
        (s_axi_rdata[0] == xlate_active || s_axi_rdata[0] == $past(xlate_active)))
        else $error("status read wrong");
    AST_UNMAPPED: assert property (rd_take && s_axi_araddr[11:2] > xlate_pkg::OFF_LAST_CMD[11:2] |=>
        s_axi_rresp == xlate_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    cover property (lo_go);
    cover property (cmd_wr && s_axi_awaddr[2]);
    cover property (rd_take && s_axi_araddr == xlate_pkg::OFF_STATUS && xlate_active);
    cover property ($fell(xlate_active));
endmodule : xlate_op_regs_assertions

bind xlate_op_regs xlate_op_regs_assertions u_chk
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .xlate_active(xlate_active), .result_valid(result_valid)
);

/* File: verif/stage1_xlate_op_regs_bench.sv */
// Self-checking bench for the translation command register slice.
// Assumes xlate_op_regs alone; the bench is the AXI4-Lite master.
module stage1_xlate_op_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr  = 12'h000;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  wstrb   = 4'h0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic [11:0] araddr  = 12'h000;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, active, res_v;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, v, d;
    logic [31:0] last    = 32'h0000_0000;
    logic [31:0] exp_q[$];
    int          fail_count = 0;
    int          n_tests    = 0;
    integer      seed       = 32'h8460_8bcd;
    always #5 aclk = ~aclk;
    xlate_op_regs dut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .xlate_active(active),
        .result_valid(res_v)
    );
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task axi_write(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= dd;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            ad = ad || awready;
            wd = wd || wready;
            awvalid <= !ad;
            wvalid  <= !wd;
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task axi_read(input logic [11:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read
    // Command write, then status read right after
    task cmd(input logic [11:0] a, input logic [31:0] dd, input logic [31:0] st, input bit push);
        axi_write(a, dd, 4'hf);
        check("cmd bresp", {30'h0000_0000, r}, 32'h0000_0000);
        axi_read(xlate_pkg::OFF_STATUS);
        check("status after cmd", v, st);
        check("active pin", {31'h0000_0000, active}, st);
        if (push)
            exp_q.push_back({dd[31:12], 10'h000, a[4:3]});
    endtask : cmd
    task check_result;
        for (int i = 0; i < 40 && v !== 32'h0000_0000; i++)
            axi_read(xlate_pkg::OFF_STATUS);
        check("status idle", v, 32'h0000_0000);
        check("result valid", {31'h0000_0000, res_v}, 32'h0000_0001);
        if (exp_q.size() > 0)
            last = exp_q.pop_front();
        axi_read(xlate_pkg::OFF_RESULT_LO);
        check("result lo", v, last);
        axi_read(xlate_pkg::OFF_RESULT_HI);
        check("result hi", v, 32'h0000_0000);
    endtask : check_result
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (5000) @(posedge aclk);
        $display("ERROR watchdog expected finish seen hang");
        fail_count++;
        tally_and_finish;
    end
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(xlate_pkg::OFF_STATUS);
        check("status reset", v, 32'h0000_0000);
        for (int k = 0; k < 8; k++)
        begin
            axi_read(12'(k * 4));
            check("cmd read", v, 32'h0000_0000);
        end
        $display("test reset_and_reads done");
        for (int k = 0; k < 4; k++)
        begin
            cmd(12'(k * 8), $random(seed), 32'h0000_0001, 1);
            check_result;
        end
        $display("test all_commands done");
        cmd(xlate_pkg::OFF_PRIV_READ_HI, $random(seed), 32'h0000_0000, 0);
        check_result;
        axi_write(xlate_pkg::OFF_STATUS, 32'hffff_ffff, 4'hf);
        axi_read(xlate_pkg::OFF_STATUS);
        check("status write", v, 32'h0000_0000);
        $display("test ignored_writes done");
        cmd(xlate_pkg::OFF_USER_READ_LO, $random(seed), 32'h0000_0001, 1);
        axi_write(xlate_pkg::OFF_USER_WRITE_LO, $random(seed), 4'hf);
        check_result;
        $display("test busy_drop done");
        axi_write(xlate_pkg::OFF_CONFIG, 32'h0000_0001, 4'hf);
        cmd(xlate_pkg::OFF_PRIV_WRITE_LO, $random(seed), 32'h0000_0000, 0);
        axi_write(xlate_pkg::OFF_CONFIG, 32'h0000_0002, 4'hf);
        cmd(xlate_pkg::OFF_PRIV_WRITE_LO, $random(seed), 32'h0000_0001, 1);
        check_result;
        axi_write(xlate_pkg::OFF_CONFIG, 32'h0000_0003, 4'hf);
        $display("test config_modes done");
        axi_read(12'h100);
        check("unmapped rresp", {30'h0000_0000, r}, {30'h0000_0000, xlate_pkg::RESP_SLVERR});
        check("unmapped rdata", v, 32'h0000_0000);
        axi_write(12'h100, 32'h0000_0000, 4'hf);
        check("unmapped bresp", {30'h0000_0000, r}, {30'h0000_0000, xlate_pkg::RESP_SLVERR});
        $display("test unmapped done");
        tally_and_finish;
    end
endmodule : stage1_xlate_op_regs_bench
